// ==== dv/host_model.sv ====
// Host computer model driving the logger register port
`timescale 1ns/1ps
module host_model
(
  input  wire logic        i_core_clk,
  input  wire logic [31:0] i_rdata,
  output logic      [7:0]  o_addr,
  output logic      [31:0] o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  // ********************
  // Bus cycles
  // ********************
  initial
  begin
    o_addr  = 8'h00;
    o_wdata = 32'h0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_core_clk);
    o_wr    <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_core_clk);
    o_rd   <= 1'b0;
    @(posedge i_core_clk);
    d = i_rdata;
  endtask
endmodule // host_model

// ==== dv/logger_sequencer_asserts.sv ====
// Port level checker for the logger sequencer
`timescale 1ns/1ps
`include "logger_regs.vh"
module logger_sequencer_asserts
#(
  parameter [31:0] TICKS_PER_SEC = 32'h2
)
(
  input wire        i_core_clk,
  input wire        i_rst,
  input wire [7:0]  i_addr,
  input wire [31:0] i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [31:0] o_rdata,
  input wire        i_digital_in,
  input wire        i_first_alarm_condition,
  input wire        o_irq,
  input wire        o_acquiring,
  input wire        o_mem_full
);
  // ********************
  // Shadow of host writes
  // ********************
  logic [1:0]  ctl_q, mode_q;
  logic [2:0]  quiet, en_q;
  logic [31:0] stg_q;
  wire cm = i_wr && i_addr == `REG_COMMIT;
  wire cw = i_wr && i_addr == `REG_CTRL;
  wire gd = quiet == 3'h7 && ctl_q == mode_q && ctl_q == 2'h1 && !i_digital_in;
  wire ga = quiet == 3'h7 && ctl_q == mode_q && ctl_q == 2'h2 && !i_first_alarm_condition;
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ctl_q  <= 2'h0;
      mode_q <= 2'h0;
      quiet  <= 3'h0;
      en_q   <= 3'h0;
    end
    else
    begin
      if (cw)
        ctl_q <= i_wdata[1:0];
      if (cm)
        mode_q <= ctl_q;
      quiet <= (cw || cm) ? 3'h0 : ((quiet == 3'h7) ? quiet : quiet + 3'h1);
      if (i_wr && i_addr == `REG_IRQ_ENABLE)
        en_q <= i_wdata[2:0];
    end
    if (i_wr && i_addr == `REG_TIME)
      stg_q <= i_wdata;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not idle");
  a_capacity_read: assert property (i_rd && i_addr == `REG_CAPACITY |=> o_rdata == `MEM_DEPTH)
    else $error("capacity wrong");
  a_full_no_acq: assert property (o_mem_full |-> !o_acquiring)
    else $error("acquiring while full");
  a_commit_clears: assert property (cm |-> ##[1:3] !o_mem_full)
    else $error("full not cleared");
  a_digital_gate: assert property (gd [*5] |-> !o_acquiring)
    else $error("acquiring with input off");
  a_alarm_gate: assert property (ga [*5] |-> !o_acquiring)
    else $error("acquiring with alarm off");
  a_irq_masked: assert property ((en_q == 3'h0) [*3] |-> !o_irq)
    else $error("irq while masked");
  a_commit_time: assert property (cm ##2 (i_rd && i_addr == `REG_TIME) |=> o_rdata == stg_q)
    else $error("clock not loaded");
  cover property (o_mem_full);
  cover property (gd [*5]);
  cover property (cm ##2 (i_rd && i_addr == `REG_TIME));
endmodule // logger_sequencer_asserts
bind logger_sequencer logger_sequencer_asserts #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_chk (.*);

// ==== dv/process_data_logger_sequencer_tb.sv ====
// Self-checking bench for the logger sequencer
`timescale 1ns/1ps
`include "logger_regs.vh"
module process_data_logger_sequencer_tb;
  logic        i_core_clk, i_rst, dig, alm, unit, wr, rd, irq, acq, full;
  logic [3:0]  ityp;
  logic [15:0] chv, off;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d, c1, seed;
  int          failures, total_checks, n, m;
  host_model h (.i_core_clk(i_core_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  logger_sequencer #(.TICKS_PER_SEC(32'h2)) dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_digital_in(dig), .i_first_alarm_condition(alm),
    .i_channel_value(chv), .i_unit_fahrenheit(unit), .i_input_type(ityp), .o_irq(irq), .o_acquiring(acq),
    .o_mem_full(full));
  // ********************
  // Helpers
  // ********************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  initial
  begin
    repeat (80000) @(posedge i_core_clk);
    failures++;
    close_out;
  end
  initial
  begin
    seed = 32'hD40CC077;
    i_rst = 1'b1;
    dig = 1'b0;
    alm = 1'b0;
    unit = seed[0];
    ityp = seed[4:1];
    chv = seed[31:16];
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    h.rd(`REG_CAPACITY, d);
    chk(d, `MEM_DEPTH);
    h.rd(`REG_SERIAL, d);
    chk(d, `SERIAL_VAL);
    h.rd(`REG_FWVER, d);
    chk(d, `FWVER_VAL);
    h.wr(`REG_CHAN, 32'h0000_001F ^ {27'h0, ityp, unit});
    h.rd(`REG_CHAN, d);
    chk(d, {27'h0, ityp, unit});
    h.rd(8'h44, d);
    chk(d, 32'h0);
    $display("test identity done");
    seed = lfsr(seed);
    off = seed[15:0];
    h.wr(`REG_OFFSET, {16'h0, off});
    h.wr(`REG_PERIOD, 32'h0);
    h.wr(`REG_CTRL, 32'h4);
    h.wr(`REG_TIME, seed);
    h.wr(`REG_COMMIT, 32'h0);
    h.rd(`REG_TIME, d);
    chk(d, seed);
    repeat (12) @(posedge i_core_clk);
    h.wr(`REG_RD_INDEX, 32'h0);
    h.rd(`REG_RD_VALUE, d);
    chk(d, {16'h0, chv + off});
    h.rd(`REG_RD_TIME, c1);
    h.wr(`REG_RD_INDEX, 32'h1);
    h.rd(`REG_RD_TIME, d);
    chk(d - c1, 32'h1);
    h.rd(`REG_COUNT, c1);
    for (n = 0; n < 10; n++)
      h.rd(`REG_RD_VALUE, d);
    h.rd(`REG_COUNT, d);
    chk({31'h0, d >= c1 + 32'hE}, 32'h1);
    h.wr(`REG_IRQ_ENABLE, 32'h1);
    repeat (6) @(posedge i_core_clk);
    chk({31'h0, irq}, 32'h1);
    h.wr(`REG_IRQ_ENABLE, 32'h0);
    repeat (3) @(posedge i_core_clk);
    chk({31'h0, irq}, 32'h0);
    $display("test immediate done");
    for (m = 1; m < 3; m++)
    begin
      dig <= 1'b0;
      alm <= 1'b0;
      h.wr(`REG_CTRL, m);
      h.wr(`REG_COMMIT, 32'h0);
      repeat (20) @(posedge i_core_clk);
      h.rd(`REG_COUNT, d);
      chk(d, 32'h0);
      if (m == 1)
        dig <= 1'b1;
      else
        alm <= 1'b1;
      repeat (20) @(posedge i_core_clk);
      h.rd(`REG_COUNT, d);
      chk({31'h0, d > 32'h4}, 32'h1);
    end
    $display("test gated done");
    alm <= 1'b0;
    h.wr(`REG_CTRL, 32'h0);
    h.wr(`REG_PERIOD, 32'h1);
    h.wr(`REG_COMMIT, 32'h0);
    for (n = 0; n < 70000 && full !== 1'b1; n++)
      @(posedge i_core_clk);
    repeat (10) @(posedge i_core_clk);
    chk({31'h0, full}, 32'h1);
    h.rd(`REG_COUNT, d);
    chk(d, `MEM_DEPTH);
    chk({31'h0, acq}, 32'h0);
    h.rd(`REG_IRQ_STATUS, d);
    chk({31'h0, d[1]}, 32'h1);
    h.wr(`REG_IRQ_CLEAR, 32'h7);
    h.rd(`REG_IRQ_STATUS, d);
    chk(d, 32'h0);
    h.wr(`REG_COMMIT, 32'h0);
    h.rd(`REG_COUNT, d);
    chk(d, 32'h0);
    chk({31'h0, full}, 32'h0);
    $display("test full done");
    close_out;
  end
endmodule // process_data_logger_sequencer_tb

// ==== hdl/logger_sequencer.v ====
// Data logger acquisition sequencer with register port, log memory and interrupt
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "logger_regs.vh"

module logger_sequencer
#(
  parameter [31:0] TICKS_PER_SEC = `TICKS_PER_SEC
)
(
  input  wire                i_core_clk,
  input  wire                i_rst,
  input  wire [7:0]          i_addr,
  input  wire [31:0]         i_wdata,
  input  wire                i_wr,
  input  wire                i_rd,
  output reg  [31:0]         o_rdata,
  input  wire                i_digital_in,
  input  wire                i_first_alarm_condition,
  input  wire [`VAL_W-1:0]   i_channel_value,
  input  wire                i_unit_fahrenheit,
  input  wire [3:0]          i_input_type,
  output reg                 o_irq,
  output reg                 o_acquiring,
  output reg                 o_mem_full
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  reg        din_s1_reg;
  reg        din_s2_reg;
  reg        al_s1_reg;
  reg        al_s2_reg;
  reg        unit_s1_reg;
  reg        unit_s2_reg;
  reg  [3:0] type_s1_reg;
  reg  [3:0] type_s2_reg;

  always @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      din_s1_reg  <= 1'b0;
      din_s2_reg  <= 1'b0;
      al_s1_reg   <= 1'b0;
      al_s2_reg   <= 1'b0;
      unit_s1_reg <= 1'b0;
      unit_s2_reg <= 1'b0;
      type_s1_reg <= 4'h0;
      type_s2_reg <= 4'h0;
    end
    else
    begin
      din_s1_reg  <= i_digital_in;
      din_s2_reg  <= din_s1_reg;
      al_s1_reg   <= i_first_alarm_condition;
      al_s2_reg   <= al_s1_reg;
      unit_s1_reg <= i_unit_fahrenheit;
      unit_s2_reg <= unit_s1_reg;
      type_s1_reg <= i_input_type;
      type_s2_reg <= type_s1_reg;
    end
  end

  // ************************************************************
  // Configuration and state registers
  // ************************************************************
  reg  [1:0]            start_mode_reg;
  reg                   wrap_reg;
  reg  [31:0]           period_reg;
  reg  [`VAL_W-1:0]     offset_reg;
  reg  [31:0]           time_stage_reg;
  reg  [`TIME_W-1:0]    rtc_reg;
  reg  [31:0]           tick_reg;
  reg                   running_reg;
  reg  [31:0]           sec_cnt_reg;
  reg  [`MEM_AW-1:0]    wr_ptr_reg;
  reg  [`MEM_AW-1:0]    count_reg;
  reg                   full_reg;
  reg  [`MEM_AW-1:0]    rd_index_reg;
  reg  [`IRQ_WIDTH-1:0] irq_stat_reg;
  reg  [`IRQ_WIDTH-1:0] irq_en_reg;

  reg  [`TIME_W-1:0]    mem_time [0:`MEM_DEPTH-1];
  reg  [`VAL_W-1:0]     mem_val  [0:`MEM_DEPTH-1];

  wire commit    = i_wr && (i_addr == `REG_COMMIT);
  wire sec_pulse = (tick_reg == TICKS_PER_SEC - 32'h1);

  // Gating of acquisition by start mode
  reg gate_ok;
  always @*
  begin
    case (start_mode_reg)
      `START_IMMEDIATE: gate_ok = 1'b1;
      `START_DIGITAL:   gate_ok = din_s2_reg;
      `START_ALARM:     gate_ok = al_s2_reg;
      default:          gate_ok = 1'b0;
    endcase
  end

  wire at_cap     = (count_reg == `MEM_DEPTH - 1);
  wire cap_block  = full_reg && !wrap_reg;
  wire sample_now = running_reg && gate_ok && !cap_block && sec_pulse &&
                    (sec_cnt_reg >= period_reg - 32'h1);
  wire wrap_evt   = sample_now && full_reg && wrap_reg;
  wire full_evt   = sample_now && at_cap && !full_reg;

  wire [`VAL_W-1:0] corrected = i_channel_value + offset_reg;
  wire [`MEM_AW-1:0] rd_addr_w;
  localparam [`MEM_AW:0] DEPTH_EXT = `MEM_DEPTH;
  wire [`MEM_AW:0]   rd_sum     = {1'b0, wr_ptr_reg} + {1'b0, rd_index_reg};
  wire [`MEM_AW:0]   rd_wrapped = rd_sum - DEPTH_EXT;
  // Oldest record sits at the write pointer once memory has wrapped
  assign rd_addr_w = !full_reg ? rd_index_reg :
                     (rd_sum >= DEPTH_EXT) ? rd_wrapped[`MEM_AW-1:0] : rd_sum[`MEM_AW-1:0];

  // ************************************************************
  // Sequencer
  // ************************************************************
  always @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      start_mode_reg <= `START_IMMEDIATE;
      wrap_reg       <= 1'b0;
      period_reg     <= `PERIOD_RST;
      offset_reg     <= {`VAL_W{1'b0}};
      time_stage_reg <= 32'h0000_0000;
      rtc_reg        <= {`TIME_W{1'b0}};
      tick_reg       <= 32'h0000_0000;
      sec_cnt_reg    <= 32'h0000_0000;
      running_reg    <= 1'b0;
      wr_ptr_reg     <= {`MEM_AW{1'b0}};
      count_reg      <= {`MEM_AW{1'b0}};
      full_reg       <= 1'b0;
      rd_index_reg   <= {`MEM_AW{1'b0}};
      irq_en_reg     <= {`IRQ_WIDTH{1'b0}};
    end
    else
    begin
      tick_reg <= sec_pulse ? 32'h0000_0000 : tick_reg + 32'h1;
      if (sec_pulse)
        rtc_reg <= rtc_reg + 32'h1;
      if (sec_pulse)
        sec_cnt_reg <= (sec_cnt_reg >= period_reg - 32'h1) ? 32'h0000_0000 : sec_cnt_reg + 32'h1;
      if (i_wr)
      begin
        case (i_addr)
          `REG_CTRL:
          begin
            start_mode_reg <= (i_wdata[`CTRL_START_MSB:`CTRL_START_LSB] > `START_ALARM) ?
                              `START_IMMEDIATE : i_wdata[`CTRL_START_MSB:`CTRL_START_LSB];
            wrap_reg       <= i_wdata[`CTRL_WRAP_BIT];
          end
          `REG_PERIOD:     period_reg <= (i_wdata < `PERIOD_MIN) ? `PERIOD_MIN : i_wdata;
          `REG_OFFSET:     offset_reg <= i_wdata[`VAL_W-1:0];
          `REG_TIME:       time_stage_reg <= i_wdata;
          `REG_RD_INDEX:   rd_index_reg <= i_wdata[`MEM_AW-1:0];
          `REG_IRQ_ENABLE: irq_en_reg <= i_wdata[`IRQ_WIDTH-1:0];
          default:         ;
        endcase
      end
      if (commit)
      begin
        rtc_reg     <= time_stage_reg;
        tick_reg    <= 32'h0000_0000;
        sec_cnt_reg <= 32'h0000_0000;
        wr_ptr_reg  <= {`MEM_AW{1'b0}};
        count_reg   <= {`MEM_AW{1'b0}};
        full_reg    <= 1'b0;
        running_reg <= 1'b1;
      end
      else if (sample_now)
      begin
        // Reads of records never touch these pointers
        wr_ptr_reg <= (wr_ptr_reg == `MEM_DEPTH - 1) ? {`MEM_AW{1'b0}} : wr_ptr_reg + 1'b1;
        if (!full_reg)
          count_reg <= count_reg + 1'b1;
        if (at_cap)
          full_reg <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Interrupt status bits
  // ************************************************************
  wire [`IRQ_WIDTH-1:0] irq_set    = {wrap_evt, full_evt && !wrap_reg, sample_now};
  wire                  irq_clr_wr = i_wr && (i_addr == `REG_IRQ_CLEAR);

  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_WIDTH; gi = gi + 1)
    begin : g_irq
      // Set wins over clear
      always @(posedge i_core_clk)
      begin
        if (i_rst)
          irq_stat_reg[gi] <= 1'b0;
        else if (irq_set[gi])
          irq_stat_reg[gi] <= 1'b1;
        else if (irq_clr_wr && i_wdata[gi])
          irq_stat_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  // Record store
  always @(posedge i_core_clk)
  begin
    if (sample_now && !commit)
    begin
      mem_time[wr_ptr_reg] <= rtc_reg;
      mem_val[wr_ptr_reg]  <= corrected;
    end
  end

  // ************************************************************
  // Register read port and outputs
  // ************************************************************
  always @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_rdata     <= 32'h0000_0000;
      o_irq       <= 1'b0;
      o_acquiring <= 1'b0;
      o_mem_full  <= 1'b0;
    end
    else
    begin
      o_irq       <= |(irq_stat_reg & irq_en_reg);
      o_acquiring <= running_reg && gate_ok && !cap_block;
      o_mem_full  <= cap_block;
      if (i_rd)
      begin
        case (i_addr)
          `REG_CTRL:       o_rdata <= {29'h0, wrap_reg, start_mode_reg};
          `REG_PERIOD:     o_rdata <= period_reg;
          `REG_OFFSET:     o_rdata <= {16'h0, offset_reg};
          `REG_TIME:       o_rdata <= rtc_reg;
          `REG_STATUS:     o_rdata <= {29'h0, running_reg && gate_ok && !cap_block, cap_block, running_reg};
          `REG_COUNT:      o_rdata <= {17'h0, count_reg};
          `REG_CAPACITY:   o_rdata <= `MEM_DEPTH;
          `REG_SERIAL:     o_rdata <= `SERIAL_VAL;
          `REG_FWVER:      o_rdata <= `FWVER_VAL;
          `REG_CHAN:       o_rdata <= {27'h0, type_s2_reg, unit_s2_reg};
          `REG_RD_INDEX:   o_rdata <= {17'h0, rd_index_reg};
          `REG_RD_TIME:    o_rdata <= mem_time[rd_addr_w];
          `REG_RD_VALUE:   o_rdata <= {16'h0, mem_val[rd_addr_w]};
          `REG_IRQ_STATUS: o_rdata <= {29'h0, irq_stat_reg};
          `REG_IRQ_ENABLE: o_rdata <= {29'h0, irq_en_reg};
          default:         o_rdata <= 32'h0000_0000;
        endcase
      end
      else
        o_rdata <= 32'h0000_0000;
    end
  end

endmodule // logger_sequencer

// ==== shared/logger_regs.vh ====
// Register offsets, fields, reset values and timing counts of the data logger sequencer
`ifndef LOGGER_REGS_VH
`define LOGGER_REGS_VH

// Register word addresses (byte offsets, one 32-bit word each)
`define REG_CTRL        8'h00
`define REG_PERIOD      8'h04
`define REG_OFFSET      8'h08
`define REG_TIME        8'h0C
`define REG_STATUS      8'h10
`define REG_COUNT       8'h14
`define REG_CAPACITY    8'h18
`define REG_SERIAL      8'h1C
`define REG_FWVER       8'h20
`define REG_CHAN        8'h24
`define REG_RD_INDEX    8'h28
`define REG_RD_TIME     8'h2C
`define REG_RD_VALUE    8'h30
`define REG_IRQ_STATUS  8'h34
`define REG_IRQ_CLEAR   8'h38
`define REG_IRQ_ENABLE  8'h3C
`define REG_COMMIT      8'h40

// Control register fields
`define CTRL_START_LSB  0
`define CTRL_START_MSB  1
`define CTRL_WRAP_BIT   2

// Start modes
`define START_IMMEDIATE 2'h0
`define START_DIGITAL   2'h1
`define START_ALARM     2'h2

// Status fields
`define STAT_RUN_BIT    0
`define STAT_FULL_BIT   1
`define STAT_ACQ_BIT    2

// Interrupt bits
`define IRQ_SAMPLE_BIT  0
`define IRQ_FULL_BIT    1
`define IRQ_WRAP_BIT    2
`define IRQ_WIDTH       3

// Memory
`define MEM_DEPTH       32700
`define MEM_AW          15
`define VAL_W           16
`define TIME_W          32

// Reset and identity values (identity values arbitrary)
`define PERIOD_RST      32'h0000_0001
`define PERIOD_MIN      32'h0000_0001
`define SERIAL_VAL      32'h0000_1234
`define FWVER_VAL       32'h0000_0100

// One second at 250 MHz
`define SEC_NS          1000000000
`define CLK_NS          4
`define TICKS_PER_SEC   (`SEC_NS / `CLK_NS)

`endif
